// file: hw/srr_pkg.sv
package srr_pkg;

  // ****************************************************************
  // Widths and bit positions
  // ****************************************************************
  localparam int SRR_W = 16;
  localparam int SRR_CMD_W = 4;
  localparam int SRR_RAW_W = 5;
  localparam int SRR_OP_CALC_BIT = 0;
  localparam int SRR_OP_TRIG_BIT = 5;
  localparam int SRR_OP_VREG_BIT = 8;
  localparam int SRR_OP_IREG_BIT = 10;
  localparam int SRR_QU_HEAT_BIT = 3;
  // Positions of the raw condition inputs inside the synchroniser vector
  localparam int SRR_RAW_CALC = 0;
  localparam int SRR_RAW_TRIG = 1;
  localparam int SRR_RAW_VREG = 2;
  localparam int SRR_RAW_IREG = 3;
  localparam int SRR_RAW_HEAT = 4;

  // ****************************************************************
  // Defined bits and values after reset
  // ****************************************************************
  localparam logic [SRR_W-1:0] SRR_OP_DEF_BITS = 16'h0521;
  localparam logic [SRR_W-1:0] SRR_QU_DEF_BITS = 16'h0008;
  localparam logic [SRR_W-1:0] SRR_MASK_RST = 16'h0000;
  localparam logic [SRR_W-1:0] SRR_EVT_RST = 16'h0000;
  localparam logic [SRR_W-1:0] SRR_ZERO = 16'h0000;
  localparam logic [SRR_RAW_W-1:0] SRR_RAW_RST = 5'h00;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  typedef enum logic [SRR_CMD_W-1:0] {
    SRR_CMD_NOP       = 4'h0,
    SRR_CMD_OP_LIVE_Q = 4'h1,
    SRR_CMD_OP_MASK_W = 4'h2,
    SRR_CMD_OP_MASK_Q = 4'h3,
    SRR_CMD_OP_LAT_Q  = 4'h4,
    SRR_CMD_PRESET    = 4'h5,
    SRR_CMD_QU_LAT_Q  = 4'h6,
    SRR_CMD_QU_LIVE_Q = 4'h7,
    SRR_CMD_QU_MASK_W = 4'h8,
    SRR_CMD_QU_MASK_Q = 4'h9
  } srr_cmd_e;

endpackage

// file: hw/srr_evt_if.sv
`timescale 1ns/1ns
`default_nettype none

interface srr_evt_if;
  import srr_pkg::*;
  logic [SRR_W-1:0] cond;
  logic rd_clr;
  logic preset;
  logic [SRR_W-1:0] evt;

  modport dev (
    input cond,
    input rd_clr,
    input preset,
    output evt
  );
  modport ctl (
    output cond,
    output rd_clr,
    output preset,
    input evt
  );
endinterface

`default_nettype wire

// file: hw/srr_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module srr_pin_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [srr_pkg::SRR_RAW_W-1:0] raw_i,
  output logic [srr_pkg::SRR_RAW_W-1:0] stable_o
);
  import srr_pkg::*;

  logic [SRR_RAW_W-1:0] s1_ff, s2_ff, s3_ff, stable_ff;
  logic [SRR_RAW_W-1:0] nxt_stable;

  // ****************************************************************
  // Per-bit acceptance: a change counts once stages two and three agree
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < SRR_RAW_W; gi++) begin : g_bit
      always_comb begin
        nxt_stable[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : stable_ff[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_ff <= SRR_RAW_RST;
      s2_ff <= SRR_RAW_RST;
      s3_ff <= SRR_RAW_RST;
      stable_ff <= SRR_RAW_RST;
    end else begin
      s1_ff <= raw_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      stable_ff <= nxt_stable;
    end
  end

  assign stable_o = stable_ff;

endmodule // srr_pin_sync

`default_nettype wire

// file: hw/srr_event_reg.sv
`timescale 1ns/1ns
`default_nettype none

module srr_event_reg #(
  parameter logic [srr_pkg::SRR_W-1:0] DEF_BITS = srr_pkg::SRR_OP_DEF_BITS
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  srr_evt_if.dev ev
);
  import srr_pkg::*;

  logic [SRR_W-1:0] prev_ff, evt_ff;
  logic [SRR_W-1:0] nxt_prev, nxt_evt, rise;

  // ****************************************************************
  // Latch rising edges; clearing read or preset loses to a new edge
  // ****************************************************************
  always_comb begin
    nxt_prev = ev.cond & DEF_BITS;
    rise = ev.cond & ~prev_ff & DEF_BITS;
    nxt_evt = ((ev.rd_clr || ev.preset) ? SRR_EVT_RST : evt_ff) | rise;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prev_ff <= SRR_EVT_RST;
      evt_ff <= SRR_EVT_RST;
    end else begin
      prev_ff <= nxt_prev;
      evt_ff <= nxt_evt;
    end
  end

  assign ev.evt = evt_ff;

endmodule // srr_event_reg

`default_nettype wire

// file: hw/srr_status_regs.sv
// Behaviour
// - Operation live value shows current state unlatched; defined bits give 0 to 1313.
// - Operation bit 10 means output regulating in constant current.
// - Operation bit 8 means output regulating in constant voltage.
// - Operation bit 5 means waiting for a trigger, driven by trigger logic.
// - Operation bit 0 means new calibration constants are being computed.
// - Operation latched register is read only, latches events, clears on read.
// - Summary bit 7 is OR of operation latched bits under operation mask.
// - Operation mask is written by command and read back with undefined bits cleared.
// - Preset clears masks and latched registers so nothing further is reported.
// - Warning registers use only bit 3, overheat; other bits unused.
// - Warning live value shows current warning state, 1 meaning active.
// - Warning latched register is read only, latches events, clears on read.
// - Summary bit 3 is OR of warning latched bits under warning mask.
// - Warning mask also gates which conditions reach the warning live value.
// - Warning mask is written by command and read back with undefined bits cleared.
// - Event sets once on rising condition; stays clear after read while active.
// - Short circuit shows current and voltage regulation plus trigger wait, e.g. 1312.
`timescale 1ns/1ns
`default_nettype none

module srr_status_regs (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic current_regulation_active_i,
  input wire logic voltage_regulation_active_i,
  input wire logic trigger_wait_i,
  input wire logic calibration_computing_i,
  input wire logic overheat_i,
  input wire logic cmd_valid_i,
  input wire logic [srr_pkg::SRR_CMD_W-1:0] cmd_code_i,
  input wire logic [srr_pkg::SRR_W-1:0] cmd_data_i,
  output logic rsp_valid_o,
  output logic [srr_pkg::SRR_W-1:0] rsp_data_o,
  output logic cmd_range_err_o,
  output logic cmd_unknown_o,
  output logic stb_oper_summary_o,
  output logic stb_ques_summary_o
);
  import srr_pkg::*;

  // ****************************************************************
  // Condition inputs come from the analog side, so they are synchronised
  // ****************************************************************
  logic [SRR_RAW_W-1:0] raw_vec, live_vec;

  always_comb begin
    raw_vec = SRR_RAW_RST;
    raw_vec[SRR_RAW_CALC] = calibration_computing_i;
    raw_vec[SRR_RAW_TRIG] = trigger_wait_i;
    raw_vec[SRR_RAW_VREG] = voltage_regulation_active_i;
    raw_vec[SRR_RAW_IREG] = current_regulation_active_i;
    raw_vec[SRR_RAW_HEAT] = overheat_i;
  end

  srr_pin_sync u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .raw_i(raw_vec),
    .stable_o(live_vec)
  );

  // ****************************************************************
  // Mask registers
  // ****************************************************************
  logic [SRR_W-1:0] op_mask_ff, qu_mask_ff;
  logic [SRR_W-1:0] nxt_op_mask, nxt_qu_mask;
  srr_cmd_e cmd;
  logic is_preset;
  logic op_mask_wr;
  logic qu_mask_wr;
  logic op_lat_rd;
  logic qu_lat_rd;

  // One strobe per action, so the mask and event logic agree on what a command
  // means; the answer logic decodes the code again in its own case statement
  always_comb begin
    cmd = srr_cmd_e'(cmd_code_i);
    is_preset = cmd_valid_i && (cmd == SRR_CMD_PRESET);
    op_mask_wr = cmd_valid_i && (cmd == SRR_CMD_OP_MASK_W);
    qu_mask_wr = cmd_valid_i && (cmd == SRR_CMD_QU_MASK_W);
    op_lat_rd = cmd_valid_i && (cmd == SRR_CMD_OP_LAT_Q);
    qu_lat_rd = cmd_valid_i && (cmd == SRR_CMD_QU_LAT_Q);
  end

  always_comb begin
    nxt_op_mask = op_mask_ff;
    nxt_qu_mask = qu_mask_ff;
    if (is_preset) begin
      nxt_op_mask = SRR_MASK_RST;
      nxt_qu_mask = SRR_MASK_RST;
    end else if (op_mask_wr) begin
      nxt_op_mask = cmd_data_i & SRR_OP_DEF_BITS;
    end else if (qu_mask_wr) begin
      nxt_qu_mask = cmd_data_i & SRR_QU_DEF_BITS;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      op_mask_ff <= SRR_MASK_RST;
      qu_mask_ff <= SRR_MASK_RST;
    end else begin
      op_mask_ff <= nxt_op_mask;
      qu_mask_ff <= nxt_qu_mask;
    end
  end

  // ****************************************************************
  // Live condition words
  // ****************************************************************
  logic [SRR_W-1:0] op_live, qu_raw, qu_live;

  always_comb begin
    op_live = SRR_ZERO;
    op_live[SRR_OP_IREG_BIT] = live_vec[SRR_RAW_IREG];
    op_live[SRR_OP_VREG_BIT] = live_vec[SRR_RAW_VREG];
    op_live[SRR_OP_TRIG_BIT] = live_vec[SRR_RAW_TRIG];
    op_live[SRR_OP_CALC_BIT] = live_vec[SRR_RAW_CALC];
    qu_raw = SRR_ZERO;
    qu_raw[SRR_QU_HEAT_BIT] = live_vec[SRR_RAW_HEAT];
    // The mask decides which warnings are watched at all, so a masked
    // warning neither shows live nor latches an event
    qu_live = qu_raw & qu_mask_ff;
  end

  // ****************************************************************
  // Latched event registers
  // ****************************************************************
  srr_evt_if op_ev ();
  srr_evt_if qu_ev ();

  always_comb begin
    op_ev.cond = op_live;
    op_ev.rd_clr = op_lat_rd;
    op_ev.preset = is_preset;
    qu_ev.cond = qu_live;
    qu_ev.rd_clr = qu_lat_rd;
    qu_ev.preset = is_preset;
  end

  srr_event_reg #(
    .DEF_BITS(SRR_OP_DEF_BITS)
  ) u_op_evt (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ev(op_ev.dev)
  );

  srr_event_reg #(
    .DEF_BITS(SRR_QU_DEF_BITS)
  ) u_qu_evt (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ev(qu_ev.dev)
  );

  // ****************************************************************
  // Query answers and command checks
  // ****************************************************************
  logic rsp_valid_ff, range_err_ff, unknown_ff;
  logic [SRR_W-1:0] rsp_data_ff;
  logic nxt_rsp_valid, nxt_range_err, nxt_unknown;
  logic [SRR_W-1:0] nxt_rsp_data;

  always_comb begin
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data = rsp_data_ff;
    nxt_range_err = 1'b0;
    nxt_unknown = 1'b0;
    if (cmd_valid_i) begin
      unique case (cmd)
        SRR_CMD_NOP: begin
        end
        SRR_CMD_OP_LIVE_Q: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data = op_live;
        end
        SRR_CMD_OP_MASK_W: begin
          nxt_range_err = |(cmd_data_i & ~SRR_OP_DEF_BITS);
        end
        SRR_CMD_OP_MASK_Q: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data = op_mask_ff;
        end
        SRR_CMD_OP_LAT_Q: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data = op_ev.evt;
        end
        SRR_CMD_PRESET: begin
        end
        SRR_CMD_QU_LAT_Q: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data = qu_ev.evt;
        end
        SRR_CMD_QU_LIVE_Q: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data = qu_live;
        end
        SRR_CMD_QU_MASK_W: begin
          nxt_range_err = |(cmd_data_i & ~SRR_QU_DEF_BITS);
        end
        SRR_CMD_QU_MASK_Q: begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data = qu_mask_ff;
        end
        default: begin
          nxt_unknown = 1'b1;
        end
      endcase
    end
  end

  // Answer word holds between queries, so a slow reader still finds it;
  // an unknown code leaves it alone and only raises its flag
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= SRR_ZERO;
      range_err_ff <= 1'b0;
      unknown_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
      range_err_ff <= nxt_range_err;
      unknown_ff <= nxt_unknown;
    end
  end

  // ****************************************************************
  // Status byte summaries, registered to keep them glitch free
  // ****************************************************************
  logic op_sum_ff, qu_sum_ff;
  logic nxt_op_sum, nxt_qu_sum;

  // Summaries follow the latched events, not the live state, so a brief
  // condition stays reported until software reads its event register
  always_comb begin
    nxt_op_sum = |(op_ev.evt & op_mask_ff);
    nxt_qu_sum = |(qu_ev.evt & qu_mask_ff);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      op_sum_ff <= 1'b0;
      qu_sum_ff <= 1'b0;
    end else begin
      op_sum_ff <= nxt_op_sum;
      qu_sum_ff <= nxt_qu_sum;
    end
  end

  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_data_o = rsp_data_ff;
  assign cmd_range_err_o = range_err_ff;
  assign cmd_unknown_o = unknown_ff;
  assign stb_oper_summary_o = op_sum_ff;
  assign stb_ques_summary_o = qu_sum_ff;

endmodule // srr_status_regs

`default_nettype wire

// file: tb/srr_status_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module srr_status_regs_assertions (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic current_regulation_active_i,
  input wire logic voltage_regulation_active_i,
  input wire logic trigger_wait_i,
  input wire logic calibration_computing_i,
  input wire logic overheat_i,
  input wire logic cmd_valid_i,
  input wire logic [srr_pkg::SRR_CMD_W-1:0] cmd_code_i,
  input wire logic [srr_pkg::SRR_W-1:0] cmd_data_i,
  input wire logic rsp_valid_o,
  input wire logic [srr_pkg::SRR_W-1:0] rsp_data_o,
  input wire logic cmd_range_err_o,
  input wire logic cmd_unknown_o,
  input wire logic stb_oper_summary_o,
  input wire logic stb_ques_summary_o
);
  import srr_pkg::*;
  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic op_q;
  logic qu_q;
  assign op_q = cmd_valid_i && (cmd_code_i inside {SRR_CMD_OP_LIVE_Q, SRR_CMD_OP_MASK_Q,
                                                    SRR_CMD_OP_LAT_Q});
  assign qu_q = cmd_valid_i && (cmd_code_i inside {SRR_CMD_QU_LAT_Q, SRR_CMD_QU_LIVE_Q,
                                                    SRR_CMD_QU_MASK_Q});
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_opw;
    cmd_valid_i && cmd_code_i == SRR_CMD_OP_MASK_W;
  endsequence
  sequence s_opq;
    cmd_valid_i && cmd_code_i == SRR_CMD_OP_MASK_Q;
  endsequence
  sequence s_quw;
    cmd_valid_i && cmd_code_i == SRR_CMD_QU_MASK_W;
  endsequence
  sequence s_quq;
    cmd_valid_i && cmd_code_i == SRR_CMD_QU_MASK_Q;
  endsequence
  // ****************************************************************
  // Checks
  // ****************************************************************
  query_answer_a: assert property ((op_q || qu_q) |=> rsp_valid_o)
    else $error("query gave no answer");
  no_spurious_a: assert property (!(op_q || qu_q) |=> !rsp_valid_o)
    else $error("answer without query");
  op_unused_a: assert property (op_q |=> (rsp_data_o & ~SRR_OP_DEF_BITS) == SRR_ZERO)
    else $error("operation answer has unused bits set");
  qu_unused_a: assert property (qu_q |=> (rsp_data_o & ~SRR_QU_DEF_BITS) == SRR_ZERO)
    else $error("warning answer has unused bits set");
  unknown_flag_a: assert property (cmd_valid_i && cmd_code_i > 4'h9
    |=> cmd_unknown_o && !rsp_valid_o) else $error("unknown code not flagged");
  range_err_a: assert property (cmd_valid_i && cmd_code_i == SRR_CMD_OP_MASK_W
    && |(cmd_data_i & ~SRR_OP_DEF_BITS) |=> cmd_range_err_o) else $error("range not flagged");
  op_readback_a: assert property (s_opw ##1 s_opq
    |=> rsp_data_o == ($past(cmd_data_i, 2) & SRR_OP_DEF_BITS)) else $error("op mask readback");
  qu_readback_a: assert property (s_quw ##1 s_quq
    |=> rsp_data_o == ($past(cmd_data_i, 2) & SRR_QU_DEF_BITS)) else $error("warn mask readback");
  preset_quiet_a: assert property (cmd_valid_i && cmd_code_i == SRR_CMD_PRESET
    |=> ##1 !stb_oper_summary_o && !stb_ques_summary_o) else $error("summary after preset");
endmodule // srr_status_regs_assertions

bind srr_status_regs srr_status_regs_assertions u_srr_status_regs_assertions (
  .clk_i(clk_i), .nrst_i(nrst_i),
  .current_regulation_active_i(current_regulation_active_i),
  .voltage_regulation_active_i(voltage_regulation_active_i),
  .trigger_wait_i(trigger_wait_i), .calibration_computing_i(calibration_computing_i),
  .overheat_i(overheat_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
  .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
  .cmd_range_err_o(cmd_range_err_o), .cmd_unknown_o(cmd_unknown_o),
  .stb_oper_summary_o(stb_oper_summary_o), .stb_ques_summary_o(stb_ques_summary_o)
);

`default_nettype wire

// file: tb/srr_status_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none

module srr_status_regs_bench;
  import srr_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ireg = 1'b0;
  logic vreg = 1'b0;
  logic tw = 1'b0;
  logic cal = 1'b0;
  logic oh = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [SRR_CMD_W-1:0] cmd_code_i = 4'h0;
  logic [SRR_W-1:0] cmd_data_i = 16'h0000;
  logic rsp_valid_o;
  logic [SRR_W-1:0] rsp_data_o;
  logic stb_oper_summary_o;
  logic stb_ques_summary_o;
  logic cmd_range_err_o;
  logic cmd_unknown_o;
  int mismatches = 0;
  int samples_checked = 0;
  srr_cmd_e qcodes[6] = '{SRR_CMD_OP_LIVE_Q, SRR_CMD_OP_MASK_Q, SRR_CMD_OP_LAT_Q,
                          SRR_CMD_QU_LAT_Q, SRR_CMD_QU_LIVE_Q, SRR_CMD_QU_MASK_Q};

  always #4 clk_i = ~clk_i;

  srr_status_regs u_srr_status_regs (
    .clk_i(clk_i), .nrst_i(nrst_i),
    .current_regulation_active_i(ireg), .voltage_regulation_active_i(vreg),
    .trigger_wait_i(tw), .calibration_computing_i(cal), .overheat_i(oh),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .cmd_range_err_o(cmd_range_err_o), .cmd_unknown_o(cmd_unknown_o),
    .stb_oper_summary_o(stb_oper_summary_o), .stb_ques_summary_o(stb_ques_summary_o)
  );

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic results();
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [SRR_W-1:0] seen, input logic [SRR_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Command is taken at the edge that starts the next send or idle
  task automatic send(input logic [SRR_CMD_W-1:0] code, input logic [SRR_W-1:0] data);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_code_i <= code;
    cmd_data_i <= data;
  endtask

  task automatic idle();
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
  endtask

  task automatic wr(input logic [SRR_CMD_W-1:0] code, input logic [SRR_W-1:0] data);
    send(code, data);
    idle();
  endtask

  task automatic qchk(input logic [SRR_CMD_W-1:0] code, input logic [SRR_W-1:0] exp);
    send(code, 16'h0000);
    idle();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      if (rsp_valid_o === 1'b1) begin
        check(rsp_data_o, exp);
        return;
      end
    end
    mismatches++;
    $display("MISMATCH at %0t: seen %h expected %h", $time, 16'h0000, exp);
    results();
  endtask

  // Synchroniser, accept stage, event and summary all land within this
  task automatic settle();
    repeat (8) @(negedge clk_i);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    foreach (qcodes[i]) qchk(qcodes[i], SRR_ZERO);
    wr(SRR_CMD_NOP, 16'h0000);
    @(negedge clk_i);
    check({15'h0000, cmd_unknown_o}, 16'h0000);
    wr(4'hA, 16'h0000);
    @(negedge clk_i);
    check({15'h0000, cmd_unknown_o}, 16'h0001);
    wr(SRR_CMD_OP_MASK_W, 16'hFFFF);
    @(negedge clk_i);
    check({15'h0000, cmd_range_err_o}, 16'h0001);
    qchk(SRR_CMD_OP_MASK_Q, 16'h0521);
    send(SRR_CMD_OP_MASK_W, 16'h0420);
    qchk(SRR_CMD_OP_MASK_Q, 16'h0420);
    send(SRR_CMD_QU_MASK_W, 16'h0003);
    qchk(SRR_CMD_QU_MASK_Q, 16'h0000);
    send(SRR_CMD_QU_MASK_W, 16'h0008);
    qchk(SRR_CMD_QU_MASK_Q, 16'h0008);
    @(posedge clk_i);
    vreg <= 1'b1;
    tw <= 1'b1;
    settle();
    qchk(SRR_CMD_OP_LIVE_Q, 16'h0120);
    check({15'h0000, stb_oper_summary_o}, 16'h0001);
    @(posedge clk_i);
    ireg <= 1'b1;
    settle();
    qchk(SRR_CMD_OP_LIVE_Q, 16'h0520);
    qchk(SRR_CMD_OP_LAT_Q, 16'h0520);
    qchk(SRR_CMD_OP_LAT_Q, 16'h0000);
    settle();
    check({15'h0000, stb_oper_summary_o}, 16'h0000);
    @(posedge clk_i);
    cal <= 1'b1;
    settle();
    qchk(SRR_CMD_OP_LIVE_Q, 16'h0521);
    check({15'h0000, stb_oper_summary_o}, 16'h0000);
    @(posedge clk_i);
    oh <= 1'b1;
    settle();
    qchk(SRR_CMD_QU_LIVE_Q, 16'h0008);
    check({15'h0000, stb_ques_summary_o}, 16'h0001);
    qchk(SRR_CMD_QU_LAT_Q, 16'h0008);
    qchk(SRR_CMD_QU_LAT_Q, 16'h0000);
    qchk(SRR_CMD_QU_LIVE_Q, 16'h0008);
    wr(SRR_CMD_QU_MASK_W, 16'h0000);
    settle();
    qchk(SRR_CMD_QU_LIVE_Q, 16'h0000);
    wr(SRR_CMD_QU_MASK_W, 16'h0008);
    settle();
    check({15'h0000, stb_ques_summary_o}, 16'h0001);
    wr(SRR_CMD_PRESET, 16'h0000);
    settle();
    check({14'h0000, stb_oper_summary_o, stb_ques_summary_o}, 16'h0000);
    qchk(SRR_CMD_OP_MASK_Q, 16'h0000);
    qchk(SRR_CMD_QU_MASK_Q, 16'h0000);
    qchk(SRR_CMD_QU_LIVE_Q, 16'h0000);
    qchk(SRR_CMD_OP_LAT_Q, 16'h0000);
    @(posedge clk_i);
    vreg <= 1'b0;
    settle();
    // Edge reaches the event register five edges on, the same edge as the read
    @(posedge clk_i);
    vreg <= 1'b1;
    repeat (3) @(posedge clk_i);
    qchk(SRR_CMD_OP_LAT_Q, 16'h0000);
    qchk(SRR_CMD_OP_LAT_Q, 16'h0100);
    results();
  end
endmodule // srr_status_regs_bench

`default_nettype wire
